// *** rtl/epd_cmd_decoder.sv ***
// Command decoder of an e-paper display controller: 4-wire serial intake,
// parameter storage, soft reset and high-voltage check sequencing, Avalon-MM registers.
// Assumes serial pins are asynchronous to i_sys_clk and the serial clock is far slower.
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns

// Functional notes
// - Command 01h takes gate count low byte, ninth bit, then 3-bit scan option.
// - Command 03h stores 5-bit gate voltage code, default 15h.
// - Command 04h stores first, second positive and negative source codes: 41h, A8h, 32h.
// - Command 10h stores sleep field: 00 normal, 01 sleep one, 11 sleep two.
// - Sleep field is 00 after power-on.
// - Command 11h stores 3-bit data entry field, default 3h.
// - Entry bits 1:0 pick Y and X step direction independently.
// - Each RAM data write steps the address along X, or Y when entry bit 2 set.
// - Command 12h restores every parameter default except the sleep field.
// - Busy is high while the soft reset runs.
// - Soft reset leaves display RAM contents alone.
// - Command 14h starts the high-voltage check; busy stays high until done.
// - Check result sits in a status bit readable by command 2Fh.
// - Byte with data/command low is a command; following high bytes are parameters.
module epd_cmd_decoder (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_dc,
  input wire logic i_spi_sda,
  output logic o_spi_sda,
  output logic o_spi_sda_oe,
  input wire logic i_hv_ready,
  output logic o_busy,
  output logic o_ram_we,
  output logic [7:0] o_ram_wdata,
  output logic [1:0] o_sleep_mode
);

  // ----------------------------------------------------------------
  // Pin synchronisation and serial clock edges
  // ----------------------------------------------------------------
  logic sclk_s, cs_n_s, dc_s, sda_s, hv_ready_s;
  logic sclk_d_q;
  logic sclk_rise, sclk_fall;

  epd_sync #(.WIDTH(5)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_async({i_spi_sclk, i_spi_cs_n, i_spi_dc, i_spi_sda, i_hv_ready}),
    .o_sync({sclk_s, cs_n_s, dc_s, sda_s, hv_ready_s})
  );

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      sclk_d_q <= 1'b0;
    else if (i_clk_en)
      sclk_d_q <= sclk_s;
  end

  assign sclk_rise = sclk_s & ~sclk_d_q;
  assign sclk_fall = ~sclk_s & sclk_d_q;

  // ----------------------------------------------------------------
  // Byte intake
  // ----------------------------------------------------------------
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic byte_vld_q, byte_dc_q;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      byte_vld_q <= 1'b0;
      byte_dc_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      byte_vld_q <= 1'b0;
      if (cs_n_s)
        bit_cnt_q <= 3'h0;
      else if (sclk_rise)
      begin
        shift_q <= {shift_q[6:0], sda_s};
        if (bit_cnt_q == 3'h7)
        begin
          bit_cnt_q <= 3'h0;
          byte_vld_q <= 1'b1;
          byte_dc_q <= dc_s;
        end
        else
          bit_cnt_q <= bit_cnt_q + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer for soft reset and high-voltage check
  // ----------------------------------------------------------------
  epd_pkg::epd_state_t state_q;
  logic [epd_pkg::TIMER_W-1:0] timer_q;
  logic hv_ok_q;
  logic clock_enable_flag_q, analog_enable_flag_q;
  logic cmd_take, data_take, soft_reset_start;

  // Bytes during busy are dropped, since the host must stay quiet then
  assign cmd_take = byte_vld_q & ~byte_dc_q & (state_q == epd_pkg::EPD_IDLE);
  assign data_take = byte_vld_q & byte_dc_q & (state_q == epd_pkg::EPD_IDLE);
  assign soft_reset_start = cmd_take & (shift_q == epd_pkg::CMD_SOFT_RESET);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      state_q <= epd_pkg::EPD_IDLE;
      timer_q <= '0;
      hv_ok_q <= 1'b0;
      o_busy <= 1'b0;
    end
    else if (i_clk_en)
    begin
      unique case (state_q)
        epd_pkg::EPD_IDLE:
        begin
          if (soft_reset_start)
          begin
            state_q <= epd_pkg::EPD_SOFT_RESET;
            timer_q <= epd_pkg::TIMER_W'(epd_pkg::SOFT_RESET_CYCLES - 1);
            o_busy <= 1'b1;
          end
          else if (cmd_take && shift_q == epd_pkg::CMD_HIGH_VOLTAGE_CHECK)
          begin
            state_q <= epd_pkg::EPD_HV_CHECK;
            timer_q <= epd_pkg::TIMER_W'(epd_pkg::HV_CHECK_CYCLES - 1);
            hv_ok_q <= 1'b0;
            o_busy <= 1'b1;
          end
        end
        epd_pkg::EPD_SOFT_RESET:
        begin
          if (timer_q == '0)
          begin
            state_q <= epd_pkg::EPD_IDLE;
            o_busy <= 1'b0;
          end
          else
            timer_q <= timer_q - 1'b1;
        end
        epd_pkg::EPD_HV_CHECK:
        begin
          if (timer_q == '0)
          begin
            state_q <= epd_pkg::EPD_IDLE;
            o_busy <= 1'b0;
            // Without both enables the analog side is off, so the check fails
            hv_ok_q <= hv_ready_s & clock_enable_flag_q & analog_enable_flag_q;
          end
          else
            timer_q <= timer_q - 1'b1;
        end
        default:
        begin
          state_q <= epd_pkg::EPD_IDLE;
          o_busy <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command and parameter slot tracking
  // ----------------------------------------------------------------
  logic [7:0] cmd_q;
  logic [2:0] slot_q;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      cmd_q <= 8'h00;
      slot_q <= 3'h0;
    end
    else if (i_clk_en)
    begin
      if (cmd_take)
      begin
        cmd_q <= shift_q;
        slot_q <= 3'h0;
      end
      else if (data_take && slot_q != 3'h7)
        slot_q <= slot_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Parameter storage
  // ----------------------------------------------------------------
  logic [8:0] gate_count_q;
  logic [2:0] scan_option_q;
  logic [4:0] gate_high_voltage_q;
  logic [7:0] source_high_voltage_first_q, source_high_voltage_second_q, source_low_voltage_q;
  logic [31:0] soft_start_q;
  logic [2:0] data_entry_q;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst || (i_clk_en && soft_reset_start))
    begin
      gate_count_q <= epd_pkg::GATE_COUNT_RST;
      scan_option_q <= epd_pkg::SCAN_OPTION_RST;
      gate_high_voltage_q <= epd_pkg::GATE_HIGH_VOLTAGE_RST;
      source_high_voltage_first_q <= epd_pkg::SOURCE_HIGH_FIRST_RST;
      source_high_voltage_second_q <= epd_pkg::SOURCE_HIGH_SECOND_RST;
      source_low_voltage_q <= epd_pkg::SOURCE_LOW_RST;
      soft_start_q <= epd_pkg::SOFT_START_RST;
      data_entry_q <= epd_pkg::DATA_ENTRY_RST;
    end
    else if (i_clk_en && data_take)
    begin
      case (cmd_q)
        epd_pkg::CMD_DRIVER_OUTPUT:
        begin
          if (slot_q == 3'h0)
            gate_count_q[7:0] <= shift_q;
          else if (slot_q == 3'h1)
            gate_count_q[8] <= shift_q[0];
          else if (slot_q == 3'h2)
            scan_option_q <= shift_q[2:0];
        end
        epd_pkg::CMD_GATE_VOLTAGE:
        begin
          if (slot_q == 3'h0)
            gate_high_voltage_q <= shift_q[4:0];
        end
        epd_pkg::CMD_SOURCE_VOLTAGE:
        begin
          if (slot_q == 3'h0)
            source_high_voltage_first_q <= shift_q;
          else if (slot_q == 3'h1)
            source_high_voltage_second_q <= shift_q;
          else if (slot_q == 3'h2)
            source_low_voltage_q <= shift_q;
        end
        epd_pkg::CMD_SOFT_START:
        begin
          if (slot_q[2] == 1'b0)
            soft_start_q[{slot_q[1:0], 3'h0} +: 8] <= shift_q;
        end
        epd_pkg::CMD_DATA_ENTRY:
        begin
          if (slot_q == 3'h0)
            data_entry_q <= shift_q[2:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Sleep survives the soft reset, so it is kept apart
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      o_sleep_mode <= epd_pkg::SLEEP_RST;
    else if (i_clk_en && data_take && cmd_q == epd_pkg::CMD_DEEP_SLEEP && slot_q == 3'h0)
      o_sleep_mode <= shift_q[1:0];
  end

  // ----------------------------------------------------------------
  // RAM write path and address counter
  // ----------------------------------------------------------------
  logic [epd_pkg::ADDR_X_W-1:0] addr_x_q;
  logic [epd_pkg::ADDR_Y_W-1:0] addr_y_q;
  logic ram_take, bus_wr;

  assign ram_take = data_take & (cmd_q == epd_pkg::CMD_RAM_WRITE);

  // The counter is not touched by soft reset: it belongs to the RAM side
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      addr_x_q <= '0;
      addr_y_q <= '0;
    end
    else if (i_clk_en)
    begin
      if (bus_wr && i_avs_address == epd_pkg::REG_ADDRESS)
      begin
        if (i_avs_byteenable[0])
          addr_x_q <= i_avs_writedata[epd_pkg::ADDR_X_W-1:0];
        if (i_avs_byteenable[2])
          addr_y_q[7:0] <= i_avs_writedata[epd_pkg::ADDR_Y_LSB +: 8];
        if (i_avs_byteenable[3])
          addr_y_q[8] <= i_avs_writedata[epd_pkg::ADDR_Y_LSB + 8];
      end
      else if (ram_take)
      begin
        if (!data_entry_q[2])
          addr_x_q <= data_entry_q[0] ? addr_x_q + 1'b1 : addr_x_q - 1'b1;
        else
          addr_y_q <= data_entry_q[1] ? addr_y_q + 1'b1 : addr_y_q - 1'b1;
      end
    end
  end

  // Only the RAM write strobe and its data byte leave here; soft reset never raises the strobe
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      o_ram_we <= 1'b0;
      o_ram_wdata <= 8'h00;
    end
    else if (i_clk_en)
    begin
      o_ram_we <= ram_take;
      if (ram_take)
        o_ram_wdata <= shift_q;
    end
  end

  // ----------------------------------------------------------------
  // Status read shift-out
  // ----------------------------------------------------------------
  logic [7:0] tx_q;
  logic tx_started_q;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      tx_q <= 8'h00;
      tx_started_q <= 1'b0;
      o_spi_sda_oe <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (cs_n_s)
        o_spi_sda_oe <= 1'b0;
      else if (cmd_take && shift_q == epd_pkg::CMD_STATUS_READ)
      begin
        tx_q <= 8'h00;
        tx_q[epd_pkg::SPI_STS_HV_OK_BIT] <= hv_ok_q;
        tx_started_q <= 1'b0;
        o_spi_sda_oe <= 1'b1;
      end
      else if (o_spi_sda_oe)
      begin
        if (sclk_rise)
          tx_started_q <= 1'b1;
        // The first falling edge would come before the host sampled D7
        if (sclk_fall && tx_started_q)
          tx_q <= {tx_q[6:0], 1'b0};
        if (byte_vld_q)
          o_spi_sda_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      o_spi_sda <= 1'b0;
    else if (i_clk_en)
      o_spi_sda <= tx_q[7];
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;

  assign bus_wr = i_avs_write & ~o_avs_waitrequest;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (i_avs_address)
      epd_pkg::REG_STATUS:
      begin
        rd_mux[epd_pkg::STS_BUSY_BIT] = o_busy;
        rd_mux[epd_pkg::STS_HV_OK_BIT] = hv_ok_q;
        rd_mux[epd_pkg::STS_SOFT_RESET_BIT] = (state_q == epd_pkg::EPD_SOFT_RESET);
        rd_mux[epd_pkg::STS_HV_CHECK_BIT] = (state_q == epd_pkg::EPD_HV_CHECK);
        rd_mux[epd_pkg::STS_SLEEP_LSB +: 2] = o_sleep_mode;
      end
      epd_pkg::REG_CONTROL:
      begin
        rd_mux[epd_pkg::CTL_CLOCK_ENABLE_BIT] = clock_enable_flag_q;
        rd_mux[epd_pkg::CTL_ANALOG_ENABLE_BIT] = analog_enable_flag_q;
      end
      epd_pkg::REG_GATE_SETUP:
      begin
        rd_mux[8:0] = gate_count_q;
        rd_mux[epd_pkg::GATE_SCAN_LSB +: 3] = scan_option_q;
      end
      epd_pkg::REG_VOLTAGE:
      begin
        rd_mux[4:0] = gate_high_voltage_q;
        rd_mux[epd_pkg::VOLT_FIRST_LSB +: 8] = source_high_voltage_first_q;
        rd_mux[epd_pkg::VOLT_SECOND_LSB +: 8] = source_high_voltage_second_q;
        rd_mux[epd_pkg::VOLT_LOW_LSB +: 8] = source_low_voltage_q;
      end
      epd_pkg::REG_SOFT_START: rd_mux = soft_start_q;
      epd_pkg::REG_ENTRY: rd_mux[2:0] = data_entry_q;
      epd_pkg::REG_ADDRESS:
      begin
        rd_mux[epd_pkg::ADDR_X_W-1:0] = addr_x_q;
        rd_mux[epd_pkg::ADDR_Y_LSB +: epd_pkg::ADDR_Y_W] = addr_y_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait cycle per access; the answer edge is the one with waitrequest low
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end
    else if (i_clk_en)
    begin
      if ((i_avs_read || i_avs_write) && o_avs_waitrequest)
      begin
        o_avs_waitrequest <= 1'b0;
        o_avs_readdata <= i_avs_read ? rd_mux : 32'h0000_0000;
      end
      else
        o_avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      clock_enable_flag_q <= 1'b0;
      analog_enable_flag_q <= 1'b0;
    end
    else if (i_clk_en && bus_wr && i_avs_address == epd_pkg::REG_CONTROL && i_avs_byteenable[0])
    begin
      clock_enable_flag_q <= i_avs_writedata[epd_pkg::CTL_CLOCK_ENABLE_BIT];
      analog_enable_flag_q <= i_avs_writedata[epd_pkg::CTL_ANALOG_ENABLE_BIT];
    end
  end

endmodule // epd_cmd_decoder

// *** inc/epd_pkg.sv ***
// Constants shared by the e-paper command decoder: codes, offsets, fields, defaults, timing.
// Assumes a 250 MHz system clock; every user writes epd_pkg::name.
package epd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SOFT_RESET_TIME_NS = 1000;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HV_CHECK_TIME_NS = 2000;
  localparam int HV_CHECK_CYCLES = (HV_CHECK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 10;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_DRIVER_OUTPUT = 8'h01;
  localparam logic [7:0] CMD_GATE_VOLTAGE = 8'h03;
  localparam logic [7:0] CMD_SOURCE_VOLTAGE = 8'h04;
  localparam logic [7:0] CMD_SOFT_START = 8'h0c;
  localparam logic [7:0] CMD_DEEP_SLEEP = 8'h10;
  localparam logic [7:0] CMD_DATA_ENTRY = 8'h11;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h12;
  localparam logic [7:0] CMD_HIGH_VOLTAGE_CHECK = 8'h14;
  localparam logic [7:0] CMD_RAM_WRITE = 8'h24;
  localparam logic [7:0] CMD_STATUS_READ = 8'h2f;

  // ----------------------------------------------------------------
  // Defaults after power-on and soft reset (SLEEP_RST after power-on only)
  // ----------------------------------------------------------------
  localparam logic [8:0] GATE_COUNT_RST = 9'h12b;
  localparam logic [2:0] SCAN_OPTION_RST = 3'h0;
  localparam logic [4:0] GATE_HIGH_VOLTAGE_RST = 5'h15;
  localparam logic [7:0] SOURCE_HIGH_FIRST_RST = 8'h41;
  localparam logic [7:0] SOURCE_HIGH_SECOND_RST = 8'ha8;
  localparam logic [7:0] SOURCE_LOW_RST = 8'h32;
  localparam logic [31:0] SOFT_START_RST = 32'h3f858c8e;
  localparam logic [1:0] SLEEP_RST = 2'h0;
  localparam logic [2:0] DATA_ENTRY_RST = 3'h3;

  // ----------------------------------------------------------------
  // Address counter
  // ----------------------------------------------------------------
  localparam int ADDR_X_W = 8;
  localparam int ADDR_Y_W = 9;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_STATUS = 5'h00;
  localparam logic [4:0] REG_CONTROL = 5'h04;
  localparam logic [4:0] REG_GATE_SETUP = 5'h08;
  localparam logic [4:0] REG_VOLTAGE = 5'h0c;
  localparam logic [4:0] REG_SOFT_START = 5'h10;
  localparam logic [4:0] REG_ENTRY = 5'h14;
  localparam logic [4:0] REG_ADDRESS = 5'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_HV_OK_BIT = 1;
  localparam int STS_SOFT_RESET_BIT = 2;
  localparam int STS_HV_CHECK_BIT = 3;
  localparam int STS_SLEEP_LSB = 4;
  localparam int CTL_CLOCK_ENABLE_BIT = 0;
  localparam int CTL_ANALOG_ENABLE_BIT = 1;
  localparam int GATE_SCAN_LSB = 16;
  localparam int VOLT_FIRST_LSB = 8;
  localparam int VOLT_SECOND_LSB = 16;
  localparam int VOLT_LOW_LSB = 24;
  localparam int ADDR_Y_LSB = 16;
  localparam int SPI_STS_HV_OK_BIT = 0;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EPD_IDLE = 3'b001,
    EPD_SOFT_RESET = 3'b010,
    EPD_HV_CHECK = 3'b100
  } epd_state_t;

endpackage

// *** rtl/epd_sync.sv ***
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/1ns
module epd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      meta_q <= '0;
      o_sync <= '0;
    end
    else if (i_clk_en)
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule // epd_sync

// *** testbench/epd_props.sv ***
// Checker on the decoder ports: bus answer, busy length, RAM strobe, sleep field.
// Assumes i_clk_en stays high, so every clock edge counts.
`timescale 1ns/1ns
module epd_props (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_busy,
  input wire logic o_ram_we,
  input wire logic [1:0] o_sleep_mode
);
  // ------------------------------
  // Busy length
  // ------------------------------
  int busy_q;
  always_ff @(posedge i_sys_clk)
  begin
    busy_q <= (i_sys_rst || !o_busy) ? 0 : busy_q + 1;
  end
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_busy_len: assert property ($fell(o_busy) |-> busy_q inside {250, 500})
    else $error("busy length");
  a_sleep_hold: assert property (o_busy |=> $stable(o_sleep_mode))
    else $error("sleep changed while busy");
  a_we_pulse: assert property (o_ram_we |=> !o_ram_we)
    else $error("ram strobe too long");
  a_we_busy: assert property (o_busy |-> !o_ram_we)
    else $error("ram write while busy");
  a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest)
    else $error("bus not answered");
  a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("wait low too long");
  a_wait_cause: assert property ($fell(o_avs_waitrequest)
    |-> $past(i_avs_read) || $past(i_avs_write))
    else $error("answer without request");
  a_write_zero: assert property (!o_avs_waitrequest && i_avs_write |-> o_avs_readdata == 32'h0)
    else $error("write answer not zero");
  c_busy: cover property ($fell(o_busy));
  c_ram: cover property (o_ram_we);
  c_read: cover property (!o_avs_waitrequest && i_avs_read);
endmodule // epd_props

bind epd_cmd_decoder epd_props chk_u (.i_sys_clk, .i_sys_rst, .i_avs_read, .i_avs_write,
  .o_avs_readdata, .o_avs_waitrequest, .o_busy, .o_ram_we, .o_sleep_mode);

// *** testbench/epd_host.sv ***
// Host model on the 4-wire serial link: a command byte, then its parameter bytes.
// Assumes one caller at a time; the serial clock stands still between frames.
`timescale 1ns/1ns
module epd_host (
  input wire logic i_dev_sda,
  input wire logic i_dev_oe,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_dc,
  output logic o_sda
);
  logic sda_q = 1'b0;
  assign o_sda = i_dev_oe ? i_dev_sda : sda_q;
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_dc = 1'b0;
  end
  task automatic put(input logic d, input logic [7:0] b, output logic [7:0] r);
    o_dc = d;
    for (int i = 7; i >= 0; i--)
    begin
      sda_q = i_dev_oe ? ~sda_q : b[i];
      #62 o_sclk = 1'b1;
      r[i] = o_sda;
      #63 o_sclk = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] c, input int n, input logic [31:0] p,
    output logic [7:0] r);
    #1 o_cs_n = 1'b0;
    put(1'b0, c, r);
    for (int k = 0; k < n; k++)
    begin
      put(1'b1, p[8*k+:8], r);
    end
    #63 o_cs_n = 1'b1;
    // Released line wanders so a stale bit never passes for data
    sda_q = ~sda_q;
    #250;
  endtask
endmodule // epd_host

// *** testbench/epd_cmd_decoder_tb_top.sv ***
// Bench for epd_cmd_decoder: register reads over Avalon, commands over the serial link.
// Assumes epd_host on the serial pins and epd_props bound to the design.
`timescale 1ns/1ns
module epd_cmd_decoder_tb_top;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_clk_en = 1'b1;
  logic [4:0] i_avs_address = 5'h0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0] i_avs_byteenable = 4'hf;
  logic i_hv_ready = 1'b0;
  logic i_spi_sclk, i_spi_cs_n, i_spi_dc, i_spi_sda, o_spi_sda, o_spi_sda_oe;
  logic o_avs_waitrequest, o_busy, o_ram_we;
  logic [31:0] o_avs_readdata, q, e;
  logic [7:0] o_ram_wdata, r;
  logic [1:0] o_sleep_mode;
  int n_errors = 0;
  int check_count = 0;
  int n_we = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk)
    if (o_ram_we === 1'b1)
      n_we <= n_we + 1;
  epd_cmd_decoder dut_u (.i_sys_clk, .i_sys_rst, .i_clk_en, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
    .i_spi_sclk, .i_spi_cs_n, .i_spi_dc, .i_spi_sda, .o_spi_sda, .o_spi_sda_oe, .i_hv_ready,
    .o_busy, .o_ram_we, .o_ram_wdata, .o_sleep_mode);
  epd_host host_u (.i_dev_sda(o_spi_sda), .i_dev_oe(o_spi_sda_oe), .o_sclk(i_spi_sclk),
    .o_cs_n(i_spi_cs_n), .o_dc(i_spi_dc), .o_sda(i_spi_sda));
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    check_count++;
    if (s !== x)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do
    begin
      @(posedge i_sys_clk);
      n++;
    end
    while (o_avs_waitrequest !== 1'b0 && n < 50);
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (o_avs_waitrequest !== 1'b0)
    begin
      chk("bus answer", 0, o_avs_waitrequest);
      end_of_test();
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (o_busy !== 1'b0 && n < 1000)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    chk("busy end", 0, o_busy);
    if (n >= 1000)
      end_of_test();
  endtask
  task automatic defaults(input string nm);
    logic [4:0] a_t [5] = '{5'h08, 5'h0c, 5'h10, 5'h14, 5'h1c};
    logic [31:0] x_t [5] = '{32'h12b, 32'h32a84115, 32'h3f858c8e, 32'h3, 32'h0};
    for (int k = 0; k < 5; k++)
    begin
      bus(1'b0, a_t[k], 32'h0);
      chk(nm, x_t[k], q);
    end
  endtask
  // ------------------------------
  // Sequence
  // ------------------------------
  initial
  begin
    repeat (3) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    chk("sleep", 2'h0, o_sleep_mode);
    defaults("default");
    $display("test power-on done");
    host_u.frame(8'h01, 4, 32'hff05ffcd, r);
    host_u.frame(8'h03, 1, 32'h0a, r);
    host_u.frame(8'h04, 3, 32'h332211, r);
    host_u.frame(8'h0c, 4, 32'h04030201, r);
    bus(1'b0, 5'h08, 32'h0);
    chk("gate", 32'h000501cd, q);
    bus(1'b0, 5'h0c, 32'h0);
    chk("volt", 32'h3322110a, q);
    bus(1'b0, 5'h10, 32'h0);
    chk("soft start", 32'h04030201, q);
    for (int v = 0; v < 4; v++)
    begin
      host_u.frame(8'h10, 1, v, r);
      chk("sleep", v, o_sleep_mode);
    end
    $display("test parameters done");
    for (int m = 0; m < 8; m++)
    begin
      host_u.frame(8'h11, 1, m, r);
      bus(1'b1, 5'h18, 32'h01000080);
      host_u.frame(8'h24, 2, 32'ha55a, r);
      bus(1'b0, 5'h14, 32'h0);
      chk("entry", m, q);
      e = m[2] ? (m[1] ? 32'h01020080 : 32'h00fe0080) : (m[0] ? 32'h01000082 : 32'h0100007e);
      bus(1'b0, 5'h18, 32'h0);
      chk("address", e, q);
      chk("ram data", 8'ha5, o_ram_wdata);
    end
    chk("ram writes", 16, n_we);
    $display("test entry done");
    host_u.frame(8'h12, 0, 32'h0, r);
    chk("busy", 1, o_busy);
    wait_idle();
    defaults("soft reset");
    chk("sleep kept", 2'h3, o_sleep_mode);
    bus(1'b0, 5'h18, 32'h0);
    chk("address kept", 32'h01020080, q);
    chk("ram writes", 16, n_we);
    $display("test soft reset done");
    bus(1'b1, 5'h04, 32'h3);
    for (int h = 1; h >= 0; h--)
    begin
      @(posedge i_sys_clk);
      i_hv_ready <= h[0];
      host_u.frame(8'h14, 0, 32'h0, r);
      chk("busy", 1, o_busy);
      wait_idle();
      bus(1'b0, 5'h00, 32'h0);
      chk("hv status", h, q[1]);
      host_u.frame(8'h2f, 1, 32'h0, r);
      chk("hv serial", h, r);
    end
    $display("test high voltage done");
    // Move away from the defaults first, so the panel setup really lands
    host_u.frame(8'h01, 3, 32'h07ffff, r);
    host_u.frame(8'h01, 3, 32'h00012b, r);
    bus(1'b0, 5'h08, 32'h0);
    chk("gate 300", 32'h0000012b, q);
    $display("test panel setup done");
    end_of_test();
  end
endmodule // epd_cmd_decoder_tb_top
